// ### verilog/prs_pkg.sv
// constants and types for the pressure and temperature readout block
// Behaviour
// - pressure is a 14-bit count; type A spans 10..90%, type B 5..95%.
// - temperature is an 11-bit count, linear, 0 = -50 C, 2047 = 150 C.
// - differential variant sits at half scale for equal ports, rises above.
// - gauge variant counts from zero gauge as the low range end.
// - two-wire variants drive interrupt on the select pin; low-power omits it.
// - low-power: measurement request wakes the part for one measurement cycle.
// - power down again when the measurement ends, before loading; result stays, marked stale after a data fetch.
// - outside low-power: valid data within 8.4 ms of reset, then a fresh update every 0.5 ms.
package prs_pkg;

  localparam int CLK_MHZ = 50;

  // pressure count scale
  localparam logic [13:0] PRS_TYPEA_LOW  = 14'h0666;
  localparam logic [13:0] PRS_TYPEA_HIGH = 14'h399A;
  localparam logic [13:0] PRS_TYPEB_LOW  = 14'h0333;
  localparam logic [13:0] PRS_TYPEB_HIGH = 14'h3CCB;
  localparam logic [13:0] PRS_MID        = 14'h2000;
  localparam logic [13:0] PRS_FULL       = 14'h3FFF;

  // temperature in sixteenths of a degree: -50 C offset, 200 C span
  localparam logic [10:0] TMP_FULL      = 11'h07FF;
  localparam int          TMP_OFFSET_16 = 800;
  localparam int          TMP_SPAN_16   = 3200;

  // timing: longest times, so the cycle counts round down
  localparam real POR_TIME_MS    = 8.4;
  localparam real UPDATE_TIME_MS = 0.5;
  localparam int  POR_CYCLES     = $rtoi(POR_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int  UPDATE_CYCLES  = $rtoi(UPDATE_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int  TIMER_W        = 20;

  // word layout, first bit out is bit 31
  localparam int WORD_W   = 32;
  localparam int IDX_W    = 6;

  // status field of the fetched word
  localparam logic [1:0] STS_FRESH   = 2'h0;
  localparam logic [1:0] STS_STALE   = 2'h2;
  localparam logic [1:0] STS_INVALID = 2'h3;

  typedef enum logic [1:0] {
    PRS_STARTUP = 2'h0,
    PRS_RUN     = 2'h1,
    PRS_SLEEP   = 2'h2,
    PRS_CONVERT = 2'h3
  } prs_state_t;

  typedef struct packed {
    logic signed [15:0] pressure;
    logic signed [12:0] temp_x16;
  } prs_sample_t;

  typedef struct packed {
    logic [1:0]  status;
    logic [13:0] pressure;
    logic [10:0] temp;
    logic [4:0]  pad;
  } prs_word_t;

endpackage

// ### verilog/prs_readout.sv
// sensor readout core: count scaling, update timing and serial link
`timescale 1ns/1ps
module prs_readout #(
  parameter bit TYPE_B        = 1'b0,
  parameter bit DIFFERENTIAL  = 1'b1,
  parameter bit LOW_POWER     = 1'b0,
  parameter bit SPI_LINK      = 1'b1,
  parameter int POR_COUNT     = prs_pkg::POR_CYCLES,
  parameter int UPDATE_COUNT  = prs_pkg::UPDATE_CYCLES,
  parameter int CONVERT_COUNT = prs_pkg::UPDATE_CYCLES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire prs_pkg::prs_sample_t sample,
  input  wire logic                 link_sclk,
  input  wire logic                 sel_n_in,
  output logic                      sel_int_out,
  output logic                      sel_int_oe,
  output logic                      miso_out,
  output logic                      miso_oe,
  output logic                      sensor_power_en,
  output logic                      data_valid
);
  import prs_pkg::*;

  localparam logic [TIMER_W-1:0] POR_T =
    TIMER_W'(POR_COUNT - 1);
  localparam logic [TIMER_W-1:0] UPD_T =
    TIMER_W'(UPDATE_COUNT - 1);
  localparam logic [TIMER_W-1:0] CNV_T =
    TIMER_W'(CONVERT_COUNT - 1);
  localparam logic [13:0] P_LOW  = TYPE_B ? PRS_TYPEB_LOW : PRS_TYPEA_LOW;
  localparam logic [13:0] P_HIGH = TYPE_B ? PRS_TYPEB_HIGH : PRS_TYPEA_HIGH;
  localparam logic signed [31:0] P_SPAN =
    32'(P_HIGH) - 32'(P_LOW);

  typedef struct packed {
    prs_state_t         state;
    logic [TIMER_W-1:0] timer;
    logic [1:0]         sel_sync;
    logic               sel_prev;
    logic [1:0]         tgl_sync;
    logic               tgl_seen;
    logic               fetched;
    logic               pending;
    prs_word_t          word;
  } prs_sys_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
  } prs_link_t;

  prs_sys_t  sys;
  prs_sys_t  next_sys;
  prs_link_t lnk;
  prs_link_t next_lnk;
  logic      fetch_tgl;
  logic      next_fetch_tgl;
  logic      link_rst_n;

  // ---------------------------------------------------------------
  // count scaling
  logic signed [31:0] p_scaled;
  logic signed [31:0] p_count;
  logic signed [31:0] t_count;
  logic [13:0]        p_code;
  logic [10:0]        t_code;

  always_comb begin
    p_scaled = 32'(sample.pressure) * P_SPAN;
    if (DIFFERENTIAL) begin
      // full input range spans both directions around half scale
      // signed on both sides, or the shift turns logical
      p_count = $signed(32'(PRS_MID)) + (p_scaled >>> 16);
    end else begin
      // negative gauge input falls below the low end toward zero
      p_count = $signed(32'(P_LOW)) + (p_scaled >>> 15);
    end
    if (p_count < 0) begin
      p_code = '0;
    end else if (p_count > 32'(PRS_FULL)) begin
      p_code = PRS_FULL;
    end else begin
      p_code = p_count[13:0];
    end
    t_count = ((32'(sample.temp_x16) + TMP_OFFSET_16)
               * $signed(32'(TMP_FULL))) / TMP_SPAN_16;
    if (t_count < 0) begin
      t_code = '0;
    end else if (t_count > 32'(TMP_FULL)) begin
      t_code = TMP_FULL;
    end else begin
      t_code = t_count[10:0];
    end
  end

  // ---------------------------------------------------------------
  // system domain
  logic sel_low;
  logic sel_rise;
  logic fetch_evt;

  always_comb begin
    next_sys = sys;
    next_sys.sel_sync = {sys.sel_sync[0], SPI_LINK ? sel_n_in : 1'b1};
    next_sys.sel_prev = sys.sel_sync[1];
    next_sys.tgl_sync = {sys.tgl_sync[0], fetch_tgl};
    next_sys.tgl_seen = sys.tgl_sync[1];
    sel_low   = !sys.sel_sync[1];
    sel_rise  = sys.sel_sync[1] && !sys.sel_prev;
    fetch_evt = sys.tgl_sync[1] ^ sys.tgl_seen;

    if (fetch_evt) begin
      next_sys.fetched = 1'b1;
    end

    case (sys.state)
      PRS_STARTUP: begin
        if (sys.timer == POR_T) begin
          next_sys.timer = '0;
          if (LOW_POWER) begin
            next_sys.state = PRS_SLEEP;
          end else begin
            next_sys.state   = PRS_RUN;
            next_sys.pending = 1'b1;
          end
        end else begin
          next_sys.timer = sys.timer + 1'b1;
        end
      end
      PRS_RUN: begin
        if (sys.timer == UPD_T) begin
          next_sys.timer   = '0;
          next_sys.pending = 1'b1;
        end else begin
          next_sys.timer = sys.timer + 1'b1;
        end
      end
      PRS_CONVERT: begin
        if (sys.timer == CNV_T) begin
          next_sys.timer   = '0;
          next_sys.pending = 1'b1;
          next_sys.state   = PRS_SLEEP;
        end else begin
          next_sys.timer = sys.timer + 1'b1;
        end
      end
      PRS_SLEEP: begin
        next_sys.timer = '0;
      end
      default: begin
        next_sys.state = PRS_STARTUP;
        next_sys.timer = '0;
      end
    endcase

    // the word must hold still while a frame reads it; the select lead
    // time gives the freeze time to land before the first clock edge
    if (sel_rise) begin
      if (sys.fetched || fetch_evt) begin
        next_sys.fetched = 1'b0;
        if (sys.word.status == STS_FRESH) begin
          next_sys.word.status = STS_STALE;
        end
      end else if (LOW_POWER && sys.state == PRS_SLEEP) begin
        // a frame with no clock edges is a measurement request
        next_sys.state = PRS_CONVERT;
        next_sys.timer = '0;
      end
    end

    // a load is held off in the cycle select rises, so it lands after a fetch frame ends: fresh data
    if (sys.pending && !sel_low && !sel_rise) begin
      next_sys.pending       = 1'b0;
      next_sys.word.status   = STS_FRESH;
      next_sys.word.pressure = p_code;
      next_sys.word.temp     = t_code;
      next_sys.word.pad      = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sys <= '{state:    PRS_STARTUP,
               timer:    '0,
               sel_sync: 2'h3,
               sel_prev: 1'b1,
               tgl_sync: 2'h0,
               tgl_seen: 1'b0,
               fetched:  1'b0,
               pending:  1'b0,
               word:     '{status: STS_INVALID, pressure: '0,
                           temp: '0, pad: '0}};
    end else begin
      sys <= next_sys;
    end
  end

  // ---------------------------------------------------------------
  // link domain: data changes on the falling clock edge, the master
  // samples on the rising edge; select high ends the frame at once
  assign link_rst_n = arst_n & sel_n_in ? 1'b0 : arst_n;

  always_comb begin
    next_lnk = lnk;
    if (lnk.idx != IDX_W'(WORD_W)) begin
      next_lnk.idx = lnk.idx + 1'b1;
    end
    next_fetch_tgl = fetch_tgl;
    // the first falling clock edge inside a frame marks it as a data fetch
    if (lnk.idx == '0) begin
      next_fetch_tgl = !fetch_tgl;
    end
  end

  always_ff @(negedge link_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lnk <= '{idx: '0};
    end else begin
      lnk <= next_lnk;
    end
  end

  // kept apart from the frame reset so a fetch is never forgotten
  always_ff @(negedge link_sclk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_tgl <= 1'b0;
    end else begin
      fetch_tgl <= next_fetch_tgl;
    end
  end

  // ---------------------------------------------------------------
  // pins
  logic [WORD_W-1:0] word_bits;

  always_comb begin
    word_bits = sys.word;
    if (lnk.idx < IDX_W'(WORD_W)) begin
      miso_out = word_bits[5'(WORD_W - 1) - lnk.idx[4:0]];
    end else begin
      miso_out = 1'b0;
    end
  end

  assign miso_oe = SPI_LINK && !sel_n_in;
  // pin five is select on the four-wire link, interrupt on a two-wire build unless low-power
  assign sel_int_oe  = !SPI_LINK && !LOW_POWER;
  assign sel_int_out = sel_int_oe && sys.word.status == STS_FRESH;
  assign sensor_power_en = sys.state != PRS_SLEEP;
  assign data_valid = sys.word.status != STS_INVALID;

endmodule

// ### dv/prs_readout_sva.sv
// port checker for the readout block
`timescale 1ns/1ps
module prs_readout_sva #(
  parameter int POR_COUNT = 200,
  parameter bit LOW_POWER = 1'b0
) (
  input wire logic                 clk_sys,
  input wire logic                 arst_n,
  input wire prs_pkg::prs_sample_t sample,
  input wire logic                 link_sclk,
  input wire logic                 sel_n_in,
  input wire logic                 sel_int_out,
  input wire logic                 sel_int_oe,
  input wire logic                 miso_out,
  input wire logic                 miso_oe,
  input wire logic                 sensor_power_en,
  input wire logic                 data_valid
);
  import prs_pkg::*;
  logic [15:0] cnt;
  // saturates so a long run cannot wrap back into the startup window
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cnt <= 16'h0000;
    else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_valid_hold: assert property (data_valid |=> data_valid)
    else $error("data valid dropped");
  a_valid_early: assert property (
    cnt < POR_COUNT - 1 |-> !data_valid)
    else $error("data valid before startup ended");
  // a low-power build holds no data until a request
  a_valid_late: assert property (
    cnt == POR_COUNT + 4 |-> data_valid == !LOW_POWER)
    else $error("data state wrong after startup");
  a_oe_select: assert property (miso_oe == !sel_n_in)
    else $error("data drive does not follow select");
  a_int_oe_low: assert property (!sel_int_oe)
    else $error("select pin driven in serial build");
  a_int_out_low: assert property (!sel_int_out)
    else $error("interrupt active in serial build");
  a_power_held: assert property (!LOW_POWER |-> sensor_power_en)
    else $error("sensor powered down in normal build");
  a_power_sleep: assert property (
    cnt == POR_COUNT + 4 |-> sensor_power_en == !LOW_POWER)
    else $error("sensor power wrong after startup");
  a_load_powered: assert property (
    $rose(data_valid) |-> $past(sensor_power_en, 2))
    else $error("result loaded without a powered measurement");
  a_miso_steady: assert property (
    link_sclk && $past(link_sclk) && !sel_n_in && !$past(sel_n_in)
    |-> $stable(miso_out)) else $error("data moved while clock high");
endmodule

// ### dv/prs_spi_master.sv
// serial master model driving select and clock of the link
`timescale 1ns/1ps
module prs_spi_master (
  output logic      link_sclk,
  output logic      sel_n_in,
  input  wire logic miso_out,
  input  wire logic miso_oe
);
  initial begin
    link_sclk = 1'b0;
    sel_n_in  = 1'b1;
  end
  // clock runs only inside a frame; an undriven data line reads unknown
  task automatic xfer(output logic [31:0] w);
    w = 32'h0000_0000;
    #7 sel_n_in = 1'b0;
    #2500;
    repeat (32) begin
      link_sclk = 1'b1;
      w = {w[30:0], miso_oe ? miso_out : 1'bx};
      #40 link_sclk = 1'b0;
      #40;
    end
    #100 sel_n_in = 1'b1;
    // the same rest would serve as two-wire bus-free time
    #2000;
  endtask

  // select low with no clock edge asks for one measurement
  task automatic request();
    #7 sel_n_in = 1'b0;
    #2500 sel_n_in = 1'b1;
  endtask
endmodule

// ### dv/prs_readout_test.sv
// testbench for the readout block with a serial master model
`timescale 1ns/1ps
module prs_readout_test;
  import prs_pkg::*;
  localparam int POR = 200;
  localparam int UPD = 100;
  localparam int CNV = 50;
  logic        clk_sys;
  logic        arst_n;
  prs_sample_t sample;
  logic        link_sclk;
  logic        sel_n_in;
  logic        miso_out;
  logic        miso_oe;
  logic        data_valid;
  logic        lp_sclk;
  logic        lp_sel_n;
  logic        lp_miso;
  logic        lp_miso_oe;
  logic        lp_power_en;
  logic        lp_valid;
  int          num_errors;
  int          check_count;

  prs_readout #(
    .POR_COUNT(POR), .UPDATE_COUNT(UPD), .CONVERT_COUNT(CNV)
  ) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .sample(sample),
    .link_sclk(link_sclk), .sel_n_in(sel_n_in), .sel_int_out(),
    .sel_int_oe(), .miso_out(miso_out), .miso_oe(miso_oe),
    .sensor_power_en(), .data_valid(data_valid));
  prs_spi_master m (.link_sclk(link_sclk), .sel_n_in(sel_n_in),
    .miso_out(miso_out), .miso_oe(miso_oe));

  // gauge, type B, low-power build on a link of its own
  prs_readout #(
    .TYPE_B(1'b1), .DIFFERENTIAL(1'b0), .LOW_POWER(1'b1),
    .POR_COUNT(POR), .UPDATE_COUNT(UPD), .CONVERT_COUNT(CNV)
  ) uut_lp (
    .clk_sys(clk_sys), .arst_n(arst_n), .sample(sample),
    .link_sclk(lp_sclk), .sel_n_in(lp_sel_n), .sel_int_out(),
    .sel_int_oe(), .miso_out(lp_miso), .miso_oe(lp_miso_oe),
    .sensor_power_en(lp_power_en), .data_valid(lp_valid));
  prs_spi_master m_lp (.link_sclk(lp_sclk), .sel_n_in(lp_sel_n),
    .miso_out(lp_miso), .miso_oe(lp_miso_oe));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic test_startup();
    arst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    chk_bit(data_valid, 1'b0);
    repeat (POR + 10) @(negedge clk_sys);
    chk_bit(data_valid, 1'b1);
    chk_bit(lp_valid, 1'b0);
    chk_bit(lp_power_en, 1'b0);
    $display("test_startup done");
  endtask

  // waits past one update period so the word holds the new sample
  task automatic read(input logic [28:0] s, output logic [31:0] w);
    @(negedge clk_sys);
    sample = s;
    repeat (UPD + 10) @(negedge clk_sys);
    m.xfer(w);
  endtask

  task automatic test_counts();
    logic [31:0] w;
    read({16'h0000, 13'h0190}, w);
    chk_word(w, {2'h0, 14'h2000, 11'h2FF, 5'h00});
    read({16'h4000, 13'h0000}, w);
    chk_word(w, {2'h0, 14'h2CCD, 11'h1FF, 5'h00});
    read({16'h8000, 13'h0960}, w);
    chk_word(w, {2'h0, 14'h0666, 11'h7FF, 5'h00});
    read({16'h8000, 13'h1CE0}, w);
    chk_word(w, {2'h0, 14'h0666, 11'h000, 5'h00});
    $display("test_counts done");
  endtask

  // request wakes the part once; fetches leave it asleep
  task automatic test_low_power();
    logic [31:0] w;
    @(negedge clk_sys);
    sample = {16'h0000, 13'h0190};
    m_lp.request();
    repeat (10) @(negedge clk_sys);
    chk_bit(lp_power_en, 1'b1);
    repeat (CNV + 10) @(negedge clk_sys);
    chk_bit(lp_power_en, 1'b0);
    chk_bit(lp_valid, 1'b1);
    // select must stay high 2 us after the request frame
    repeat (40) @(negedge clk_sys);
    m_lp.xfer(w);
    chk_word(w, {2'h0, 14'h0333, 11'h2FF, 5'h00});
    m_lp.xfer(w);
    chk_word(w, {2'h2, 14'h0333, 11'h2FF, 5'h00});
    chk_bit(lp_power_en, 1'b0);
    @(negedge clk_sys);
    sample = {16'h4000, 13'h0190};
    m_lp.request();
    repeat (CNV + 60) @(negedge clk_sys);
    m_lp.xfer(w);
    chk_word(w, {2'h0, 14'h1FFF, 11'h2FF, 5'h00});
    $display("test_low_power done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    sample = '0;
    num_errors = 0;
    check_count = 0;
    test_startup();
    test_counts();
    test_low_power();
    // second reset in mid-run must restart the startup wait
    test_startup();
    finish_test();
  end

  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule

bind prs_readout prs_readout_sva #(
  .POR_COUNT(POR_COUNT), .LOW_POWER(LOW_POWER)
) chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .sample(sample),
  .link_sclk(link_sclk), .sel_n_in(sel_n_in), .sel_int_out(sel_int_out),
  .sel_int_oe(sel_int_oe), .miso_out(miso_out), .miso_oe(miso_oe),
  .sensor_power_en(sensor_power_en), .data_valid(data_valid));
